// ===== design/lpr_regs.svh
// Register offsets, flag positions, reset values and interval figures of the result readout
`ifndef LPR_REGS_SVH
`define LPR_REGS_SVH

// Byte addresses seen by the serial host
`define LPR_ADDR_DEVICE_IDENTITY 8'h86
`define LPR_ADDR_MAKER_IDENTITY  8'h87
`define LPR_ADDR_LIGHT_CH1_LOW   8'h88
`define LPR_ADDR_LIGHT_CH1_HIGH  8'h89
`define LPR_ADDR_LIGHT_CH0_LOW   8'h8a
`define LPR_ADDR_LIGHT_CH0_HIGH  8'h8b
`define LPR_ADDR_RESULT_FLAGS    8'h8c
`define LPR_ADDR_PROX_LOW        8'h8d
`define LPR_ADDR_PROX_HIGH       8'h8e

// Field positions of sensor_result_flags
`define LPR_FLAG_PROX_NEW        0
`define LPR_FLAG_PROX_EVENT      1
`define LPR_FLAG_LIGHT_NEW       2
`define LPR_FLAG_LIGHT_EVENT     3
`define LPR_FLAG_LIGHT_RANGE     4
`define LPR_FLAGS_RESET          8'h00
`define LPR_RESULT_RESET         8'h00

// Identity register fields
`define LPR_ID_PART_MSB          7
`define LPR_ID_PART_LSB          4
`define LPR_ID_REV_MSB           3
`define LPR_ID_REV_LSB           0

// Light repeat interval encodings and their periods in milliseconds
`define LPR_REPEAT_CODE_RESET    3'h3
`define LPR_REPEAT_MS_50         16'd50
`define LPR_REPEAT_MS_100        16'd100
`define LPR_REPEAT_MS_200        16'd200
`define LPR_REPEAT_MS_500        16'd500
`define LPR_REPEAT_MS_1000       16'd1000
`define LPR_REPEAT_MS_2000       16'd2000

`endif

// ===== design/lpr_pkg.sv
// Types shared by the light and proximity result readout
package lpr_pkg;

  // One light measurement as it travels to the readable registers
  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
    logic        range_low;
    logic        event_hit;
  } lpr_light_t;

  // One proximity measurement
  typedef struct packed {
    logic [10:0] count;
    logic        event_hit;
  } lpr_prox_t;

  // Snapshot handed from the measurement domain to the link domain
  typedef struct packed {
    lpr_light_t light;
    lpr_prox_t  prox;
    logic       light_fresh;
    logic       prox_fresh;
  } lpr_snap_t;

  // Whole state of the measurement-side logic
  typedef struct packed {
    lpr_light_t  light_sh;
    lpr_prox_t   prox_sh;
    logic        light_pend;
    logic        prox_pend;
    lpr_snap_t   xfer;
    logic        req;
    logic [2:0]  ack_s;
    logic        ack_f;
    logic [2:0]  busy_s;
    logic        busy_f;
    logic [15:0] repeat_ms;
  } lpr_core_t;

  // Whole state of the link-side logic
  typedef struct packed {
    lpr_light_t light;
    lpr_prox_t  prox;
    logic       light_new;
    logic       prox_new;
    logic [2:0] req_s;
    logic       req_f;
    logic       seen;
    logic       busy;
    logic [7:0] rd_data;
  } lpr_link_t;

endpackage

// ===== design/lpr_readout.sv
// Light and proximity result registers with read coherency across the serial link clock
//
// Behaviour
// [RULE1] Light repeat code 0..4 gives 50,100,200,500,1000 ms; 5..7 give 2000 ms.
// [RULE2] Identity byte: part number in bits 7:4, revision in bits 3:0, read-only.
// [RULE3] Next address holds a read-only 8-bit maker code.
// [RULE4] Light channel 1 result: low byte first address, high byte next.
// [RULE5] Light channel 0 result: low byte first address, high byte next.
// [RULE6] Both bytes of a pair stay frozen from read start to read end.
// [RULE7] Finished results wait in shadow storage, copied out when no read runs.
// [RULE8] Proximity result: low byte in first register, upper bits in second.
// [RULE9] Read-only flag register, reset to zero, holds event and new-data state.
// [RULE10] New-data flag sets when a result reaches that sensor's registers.
// [RULE11] New-data flag clears when the host reads that sensor's result.
// [RULE12] Light new-data in bit 2, proximity new-data in bit 0.
// [RULE13] Light event bit 3, proximity event bit 1, set when outside limits.
// [RULE14] Flag bit 4 gives light range: 0 high range, 1 low range.
// [RULE15] Proximity upper bits sit in bits 2:0; bits 7:3 carry nothing.
// [RULE16] Event only when value lies outside the upper and lower limits.
// [RULE17] Flags keep updating even with the interrupt pin disabled.
// [RULE18] Shadow keeps only the latest result; newer overwrites untransferred older.
// [RULE19] Host reads both bytes of a pair in one read transaction.
`timescale 1ns/1ps
`include "lpr_regs.svh"

module lpr_readout #(
  parameter logic [3:0] PART_NUMBER = 4'h1,  // Arbitrary value
  parameter logic [3:0] REVISION    = 4'h0,  // Arbitrary value
  parameter logic [7:0] MAKER_CODE  = 8'h5a  // Arbitrary value
) (
  // Measurement domain
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        light_meas_valid,
  input  wire logic [15:0] light_ch1_in,
  input  wire logic [15:0] light_ch0_in,
  input  wire logic        light_range_low_in,
  input  wire logic [15:0] light_upper,
  input  wire logic [15:0] light_lower,
  input  wire logic        prox_meas_valid,
  input  wire logic [10:0] prox_count_in,
  input  wire logic [10:0] prox_upper,
  input  wire logic [10:0] prox_lower,
  input  wire logic [2:0]  light_repeat_code,
  output logic      [15:0] light_repeat_ms,
  // Link domain, driven by the serial protocol engine
  input  wire logic        link_clk,
  input  wire logic        rd_start,
  input  wire logic        rd_stop,
  input  wire logic        rd_en,
  input  wire logic [7:0]  rd_addr,
  output logic      [7:0]  rd_data
);

  // Period of the light measurement for a repeat code
  function automatic logic [15:0] repeat_ms_of(input logic [2:0] code);
    logic [15:0] ms;
    ms = `LPR_REPEAT_MS_2000;
    case (code)
      3'h0: ms = `LPR_REPEAT_MS_50;
      3'h1: ms = `LPR_REPEAT_MS_100;
      3'h2: ms = `LPR_REPEAT_MS_200;
      3'h3: ms = `LPR_REPEAT_MS_500;
      3'h4: ms = `LPR_REPEAT_MS_1000;
      default: ms = `LPR_REPEAT_MS_2000;
    endcase
    return ms;
  endfunction

  // True when a value lies outside the band between the limits
  function automatic logic outside(input logic [15:0] val, input logic [15:0] up, input logic [15:0] low);
    return (val > up) || (val < low);
  endfunction

  // Three-stage synchroniser filter: a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction

  // Measurement domain state; link state is declared here too, since each side reads the other
  lpr_pkg::lpr_core_t c_q;
  lpr_pkg::lpr_core_t c_d;
  logic               c_idle;
  lpr_pkg::lpr_link_t l_q;
  lpr_pkg::lpr_link_t l_d;
  logic               l_rd_light;
  logic               l_rd_prox;

  always_comb begin
    c_d       = c_q;
    c_idle    = 1'b0;
    c_d.repeat_ms = repeat_ms_of(light_repeat_code);  // [RULE1]
    // Pull in link state; only stage one reads the crossing signal
    c_d.ack_s  = {c_q.ack_s[1:0], l_q.seen};
    c_d.ack_f  = filt(c_q.ack_s, c_q.ack_f);
    c_d.busy_s = {c_q.busy_s[1:0], l_q.busy};
    c_d.busy_f = filt(c_q.busy_s, c_q.busy_f);
    // Hand over the shadow only when the link has taken the last one and no read runs
    c_idle = (c_q.ack_f == c_q.req) && !c_q.busy_f;
    if (c_idle && (c_q.light_pend || c_q.prox_pend)) begin  // [RULE7]
      c_d.xfer.light       = c_q.light_sh;
      c_d.xfer.prox        = c_q.prox_sh;
      c_d.xfer.light_fresh = c_q.light_pend;
      c_d.xfer.prox_fresh  = c_q.prox_pend;
      c_d.req              = ~c_q.req;
      c_d.light_pend       = 1'b0;
      c_d.prox_pend        = 1'b0;
    end
    // New results overwrite the shadow; a result in the launch cycle stays pending
    if (light_meas_valid) begin  // [RULE18]
      c_d.light_sh.ch1       = light_ch1_in;
      c_d.light_sh.ch0       = light_ch0_in;
      c_d.light_sh.range_low = light_range_low_in;
      c_d.light_sh.event_hit = outside(light_ch0_in, light_upper, light_lower);  // [RULE16]
      c_d.light_pend         = 1'b1;
    end
    if (prox_meas_valid) begin  // [RULE18]
      c_d.prox_sh.count     = prox_count_in;
      c_d.prox_sh.event_hit = outside({5'h00, prox_count_in}, {5'h00, prox_upper},
                                      {5'h00, prox_lower});  // [RULE16]
      c_d.prox_pend         = 1'b1;
    end
  end

  // Measurement-domain register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_q           <= '0;
      c_q.repeat_ms <= `LPR_REPEAT_MS_500;
    end else begin
      c_q <= c_d;
    end
  end

  assign light_repeat_ms = c_q.repeat_ms;

  // Link domain: read decode, new-data flags and snapshot capture
  always_comb begin
    l_d        = l_q;
    l_rd_light = 1'b0;
    l_rd_prox  = 1'b0;
    l_d.req_s  = {l_q.req_s[1:0], c_q.req};
    l_d.req_f  = filt(l_q.req_s, l_q.req_f);
    // Read window: open on start, closed on stop
    if (rd_start) begin
      l_d.busy = 1'b1;  // [RULE6]
    end else if (rd_stop) begin
      l_d.busy = 1'b0;  // [RULE6]
    end
    // Byte reads; the snapshot cannot move while busy, so pairs stay coherent
    if (rd_en) begin
      l_rd_light = (rd_addr >= `LPR_ADDR_LIGHT_CH1_LOW) && (rd_addr <= `LPR_ADDR_LIGHT_CH0_HIGH);
      l_rd_prox  = (rd_addr == `LPR_ADDR_PROX_LOW) || (rd_addr == `LPR_ADDR_PROX_HIGH);
      if (rd_addr == `LPR_ADDR_DEVICE_IDENTITY) begin
        l_d.rd_data = {PART_NUMBER, REVISION};  // [RULE2]
      end else if (rd_addr == `LPR_ADDR_MAKER_IDENTITY) begin
        l_d.rd_data = MAKER_CODE;  // [RULE3]
      end else if (rd_addr == `LPR_ADDR_LIGHT_CH1_LOW) begin
        l_d.rd_data = l_q.light.ch1[7:0];  // [RULE4]
      end else if (rd_addr == `LPR_ADDR_LIGHT_CH1_HIGH) begin
        l_d.rd_data = l_q.light.ch1[15:8];  // [RULE4]
      end else if (rd_addr == `LPR_ADDR_LIGHT_CH0_LOW) begin
        l_d.rd_data = l_q.light.ch0[7:0];  // [RULE5]
      end else if (rd_addr == `LPR_ADDR_LIGHT_CH0_HIGH) begin
        l_d.rd_data = l_q.light.ch0[15:8];  // [RULE5]
      end else if (rd_addr == `LPR_ADDR_RESULT_FLAGS) begin
        l_d.rd_data = `LPR_FLAGS_RESET;  // [RULE9]
        l_d.rd_data[`LPR_FLAG_PROX_NEW]    = l_q.prox_new;         // [RULE12]
        l_d.rd_data[`LPR_FLAG_PROX_EVENT]  = l_q.prox.event_hit;   // [RULE13]
        l_d.rd_data[`LPR_FLAG_LIGHT_NEW]   = l_q.light_new;        // [RULE12]
        l_d.rd_data[`LPR_FLAG_LIGHT_EVENT] = l_q.light.event_hit;  // [RULE13]
        l_d.rd_data[`LPR_FLAG_LIGHT_RANGE] = l_q.light.range_low;  // [RULE14]
      end else if (rd_addr == `LPR_ADDR_PROX_LOW) begin
        l_d.rd_data = l_q.prox.count[7:0];  // [RULE8]
      end else if (rd_addr == `LPR_ADDR_PROX_HIGH) begin
        l_d.rd_data = {5'h00, l_q.prox.count[10:8]};  // [RULE15]
      end else begin
        l_d.rd_data = 8'h00;  // Unmapped addresses read as zero
      end
    end
    // Reading a sensor's result marks its data as old
    if (l_rd_light) begin
      l_d.light_new = 1'b0;  // [RULE11]
    end
    if (l_rd_prox) begin
      l_d.prox_new = 1'b0;  // [RULE11]
    end
    // Take a waiting snapshot only outside a read; event state updates regardless of interrupt setup
    if ((l_q.req_f != l_q.seen) && !l_q.busy) begin  // [RULE7] [RULE17]
      l_d.seen = l_q.req_f;
      if (c_q.xfer.light_fresh) begin
        l_d.light     = c_q.xfer.light;
        l_d.light_new = 1'b1;  // [RULE10]
      end
      if (c_q.xfer.prox_fresh) begin
        l_d.prox     = c_q.xfer.prox;
        l_d.prox_new = 1'b1;  // [RULE10]
      end
    end
  end

  // Link-domain register; the link clock may stop between frames, which only delays updates
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign rd_data = l_q.rd_data;

endmodule

// ===== dv/lpr_readout_properties.sv
// Port checker for the light and proximity result readout
`timescale 1ns/1ps
module lpr_readout_chk #(
  parameter logic [3:0] PART_NUMBER = 4'h1,
  parameter logic [3:0] REVISION    = 4'h0,
  parameter logic [7:0] MAKER_CODE  = 8'h5a
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [2:0]  light_repeat_code,
  input wire logic [15:0] light_repeat_ms,
  input wire logic        link_clk,
  input wire logic        rd_start,
  input wire logic        rd_stop,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_addr,
  input wire logic [7:0]  rd_data
);
  localparam logic [15:0] MS_T [8] = '{16'd50, 16'd100, 16'd200, 16'd500, 16'd1000, 16'd2000, 16'd2000, 16'd2000};
  logic open_q;
  // Read frame tracker; only inside a frame can no transfer slip between two reads
  always_ff @(posedge link_clk or negedge arst_n)
    if (!arst_n) open_q <= 1'b0;
    else if (rd_start) open_q <= 1'b1;
    else if (rd_stop) open_q <= 1'b0;
  property p_repeat;
    @(posedge clk) disable iff (!arst_n) $past(arst_n) |-> light_repeat_ms == MS_T[$past(light_repeat_code)];
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat interval decode wrong");
  property p_ident;
    @(posedge link_clk) disable iff (!arst_n) rd_en && rd_addr == 8'h86 |=> rd_data == {PART_NUMBER, REVISION};
  endproperty
  a_ident: assert property (p_ident) else $error("identity byte wrong");
  property p_maker;
    @(posedge link_clk) disable iff (!arst_n) rd_en && rd_addr == 8'h87 |=> rd_data == MAKER_CODE;
  endproperty
  a_maker: assert property (p_maker) else $error("maker byte wrong");
  property p_phigh;
    @(posedge link_clk) disable iff (!arst_n) rd_en && rd_addr == 8'h8e |=> rd_data[7:3] == 5'h00;
  endproperty
  a_phigh: assert property (p_phigh) else $error("proximity high byte has stray bits");
  property p_flagtop;
    @(posedge link_clk) disable iff (!arst_n) rd_en && rd_addr == 8'h8c |=> rd_data[7:5] == 3'h0;
  endproperty
  a_flagtop: assert property (p_flagtop) else $error("flag byte has stray bits");
  property p_hold;
    @(posedge link_clk) disable iff (!arst_n) !rd_en |=> $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read byte moved without a read");
  property p_lclr;
    @(posedge link_clk) disable iff (!arst_n)
      open_q && rd_en && rd_addr inside {[8'h88:8'h8b]} ##1 rd_en && rd_addr == 8'h8c |=> !rd_data[2];
  endproperty
  a_lclr: assert property (p_lclr) else $error("light new flag kept after read");
  property p_pclr;
    @(posedge link_clk) disable iff (!arst_n) open_q && rd_en && rd_addr == 8'h8e ##1 rd_en && rd_addr == 8'h8c |=> !rd_data[0];
  endproperty
  a_pclr: assert property (p_pclr) else $error("proximity new flag kept after read");
  c_pair: cover property (@(posedge link_clk) disable iff (!arst_n) rd_en && rd_addr == 8'h88 ##1 rd_en && rd_addr == 8'h89);
  c_gap: cover property (@(posedge link_clk) disable iff (!arst_n) open_q && !rd_en ##1 rd_en);
  c_slow: cover property (@(posedge clk) disable iff (!arst_n) light_repeat_code == 3'h7);
endmodule
bind lpr_readout lpr_readout_chk #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION), .MAKER_CODE(MAKER_CODE))
  u_lpr_readout_chk (.*);

// ===== dv/lpr_host_model.sv
// Serial host model that clocks the link only during its transactions: 16 address-phase ticks, then start, reads and stop
`timescale 1ns/1ps
module lpr_host_model (
  output logic            link_clk,
  output logic            rd_start,
  output logic            rd_stop,
  output logic            rd_en,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [7:0] got[$];
  logic       mid;
  // Idle levels; the address is scrambled in the read gap and after each stop
  initial begin
    {link_clk, rd_start, rd_stop, rd_en, mid} = '0;
    rd_addr = 8'h00;
  end
  // One link period; outputs move 1 ns after the rising edge
  task automatic tick();
    #14 link_clk = 1'b0;
    #15 link_clk = 1'b1;
    #1;
  endtask
  // Address phase, start, reads (idle gap after the first), stop
  task automatic xact(input logic [7:0] al[$], input int gap);
    repeat (16) tick();
    rd_start = 1'b1;
    tick();
    rd_start = 1'b0;
    foreach (al[i]) begin
      rd_en = 1'b1;
      rd_addr = al[i];
      tick();
      got.push_back(rd_data);
      if (i == 0 && gap > 0) begin
        rd_en = 1'b0;
        rd_addr = ~rd_addr;
        mid = 1'b1;
        repeat (gap) tick();
      end
    end
    rd_en = 1'b0;
    rd_stop = 1'b1;
    tick();
    rd_stop = 1'b0;
    rd_addr = ~rd_addr;
    mid = 1'b0;
  endtask
endmodule

// ===== dv/test_light_proximity_result_readout.sv
// Self-checking bench for the result readout
`timescale 1ns/1ps
module test_light_proximity_result_readout;
  localparam logic [3:0] PN = 4'h9;  // Arbitrary value
  localparam logic [3:0] RV = 4'h2;  // Arbitrary value
  localparam logic [7:0] MK = 8'h3c; // Arbitrary value
  logic        clk, arst_n, light_meas_valid, light_range_low_in, prox_meas_valid, link_clk, rd_start, rd_stop, rd_en;
  logic [15:0] light_ch1_in, light_ch0_in, light_upper, light_lower, light_repeat_ms;
  logic [10:0] prox_count_in, prox_upper, prox_lower;
  logic [7:0]  rd_addr, rd_data, qf[$], qp[$];
  logic [2:0]  light_repeat_code;
  int          fail_count, checks, i, k, m_ch1, m_ch0, m_rng, m_lev, m_px, m_pev, n_l, n_p;
  int          s_ch1, s_ch0, s_rng, s_lev, s_px, s_pev;
  int          rep_t[8] = '{50, 100, 200, 500, 1000, 2000, 2000, 2000};
  lpr_readout #(.PART_NUMBER(PN), .REVISION(RV), .MAKER_CODE(MK)) u_lpr_readout (.*);
  lpr_host_model u_lpr_host_model (.*);
  // Measurement clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Model byte at an address, from the visible results
  function automatic logic [7:0] exp_b(input logic [7:0] a);
    case (a)
      8'h86: return {PN, RV};
      8'h87: return MK;
      8'h88: return m_ch1[7:0];
      8'h89: return m_ch1[15:8];
      8'h8a: return m_ch0[7:0];
      8'h8b: return m_ch0[15:8];
      8'h8c: return {3'h0, m_rng[0], m_lev[0], n_l[0], m_pev[0], n_p[0]};
      8'h8d: return m_px[7:0];
      8'h8e: return {5'h00, m_px[10:8]};
      default: return 8'h00;
    endcase
  endfunction
  // Random result of each sensor into the shadow; caller drops the strobes
  task automatic meas();
    light_ch1_in = 16'($urandom);
    light_ch0_in = 16'($urandom);
    prox_count_in = 11'($urandom);
    light_range_low_in = 1'($urandom);
    {light_upper, light_lower} = $urandom;
    {prox_upper, prox_lower} = 22'($urandom);
    {light_meas_valid, prox_meas_valid} = 2'b11;
    s_ch1 = light_ch1_in;
    s_ch0 = light_ch0_in;
    s_rng = light_range_low_in;
    s_px = prox_count_in;
    s_lev = light_ch0_in > light_upper || light_ch0_in < light_lower;
    s_pev = prox_count_in > prox_upper || prox_count_in < prox_lower;
    @(posedge clk) #1;
  endtask
  // Shadow reaches the readable registers once no frame is open
  task automatic commit();
    {m_ch1, m_ch0, m_rng, m_lev} = {s_ch1, s_ch0, s_rng, s_lev};
    {m_px, m_pev, n_l, n_p} = {s_px, s_pev, 32'd1, 32'd1};
  endtask
  // One frame at a random phase, each byte compared, then read-clear applied
  task automatic frame(input logic [7:0] a[$], input int gap);
    #($urandom_range(9000) * 1ps);
    u_lpr_host_model.xact(a, gap);
    foreach (a[j]) begin
      chk(u_lpr_host_model.got.pop_front(), exp_b(a[j]));
      if (a[j] inside {[8'h88:8'h8b]}) n_l = 0;
      if (a[j] inside {8'h8d, 8'h8e}) n_p = 0;
    end
  endtask
  // Hang guard
  initial begin
    #200us;
    fail_count++;
    close_out();
  end
  initial begin
    {arst_n, light_meas_valid, prox_meas_valid, light_range_low_in, light_ch1_in, light_ch0_in} = '0;
    {light_upper, light_lower, prox_count_in, prox_upper, prox_lower} = '0;
    light_repeat_code = 3'h3;
    void'($urandom(32'he25998d6));
    qf = '{8'h8c, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8c, 8'h8f, 8'h85};
    qp = '{8'h88, 8'h89};
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    frame(qf, 0);
    // Random results; odd rounds send two back to back so only the later survives
    for (i = 0; i < 6; i++) begin
      @(posedge clk) #1;
      meas();
      if (i[0]) meas();
      {light_meas_valid, prox_meas_valid} = 2'b00;
      commit();
      repeat (20) @(posedge clk);
      frame(qf, 0);
    end
    // A result lands between the two bytes of a pair and waits for the stop
    fork
      frame(qp, 8);
      begin
        for (k = 0; k < 300 && u_lpr_host_model.mid !== 1'b1; k++) @(posedge clk);
        if (k == 300) begin
          fail_count++;
          close_out();
        end
        repeat (6) @(posedge clk);
        #1 meas();
        {light_meas_valid, prox_meas_valid} = 2'b00;
      end
    join
    commit();
    frame(qf, 0);
    for (i = 0; i < 8; i++) begin
      @(posedge clk) #1 light_repeat_code = 3'(i);
      repeat (2) @(posedge clk);
      #1 chk(light_repeat_ms, 16'(rep_t[i]));
    end
    close_out();
  end
endmodule
